// ### core/cpec_pkg.sv
package cpec_pkg;
   // core clock period
   localparam int CLK_NS = 4;

   // wait after each bulk erase: the longest the device may need to finish
   localparam int ERASE_MS  = 10;
   localparam int ERASE_CYC = (ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
   // undriven gap between words and clock low to next frame rise
   localparam int GAP_US    = 1;
   localparam int GAP_CYC   = (GAP_US * 1000 + CLK_NS - 1) / CLK_NS;
   // mode exit delay and high voltage discharge time
   localparam int EXIT_US   = 1;
   localparam int EXIT_CYC  = (EXIT_US * 1000 + CLK_NS - 1) / CLK_NS;
   localparam int DIS_US    = 100;
   localparam int DIS_CYC   = (DIS_US * 1000 + CLK_NS - 1) / CLK_NS;
   // hold after the programming voltage rises, before the first clock
   localparam int HOLD_US   = 5;
   localparam int HOLD_CYC  = (HOLD_US * 1000 + CLK_NS - 1) / CLK_NS;
   // link half period; long enough that read data is valid at the fall
   localparam int HALF_NS   = 100;
   localparam int HALF_CYC  = (HALF_NS + CLK_NS - 1) / CLK_NS;

   localparam logic [4:0] HALF_END       = 5'(HALF_CYC - 1);
   localparam logic [7:0] GAP_END        = 8'(GAP_CYC - 1);
   localparam logic [4:0] CMD_LAST_HALF  = 5'h0B;
   localparam logic [4:0] DATA_LAST_HALF = 5'h1F;

   typedef logic [21:0] cpec_tmr_t;

   // command codes, upper two bits sent as zero
   localparam logic [5:0] CMD_ERASE = 6'h09;
   localparam logic [5:0] CMD_READ  = 6'h04;
   localparam logic [5:0] CMD_INC   = 6'h06;

   // address map and checksum masks
   localparam logic [10:0] CFG_ADDR   = 11'h7FF;
   localparam logic [10:0] PROG_LAST  = 11'h5FE;
   localparam logic [10:0] DATA_FIRST = 11'h600;
   localparam logic [10:0] ID_FIRST   = 11'h640;
   localparam logic [10:0] ID_LAST    = 11'h643;
   localparam logic [15:0] CFG_MASK   = 16'h007F;
   localparam logic [15:0] NIB_MASK   = 16'h000F;
   localparam int          PROT_MSB   = 10;
   localparam int          PROT_LSB   = 7;
   localparam logic [3:0]  PROT_ON    = 4'h2;
   localparam logic [1:0]  ERASE_RUNS = 2'h3;
endpackage : cpec_pkg

// ### core/cpec_link_if.sv
`timescale 1ns/1ps
// one word-level operation between sequencer and bit engine
interface cpec_link_if;
   logic        req;
   logic [5:0]  cmd;
   logic        rd;
   logic        done;
   logic [11:0] rdata;

   modport ctrl (output req, output cmd, output rd, input done, input rdata);
   modport phy  (input req, input cmd, input rd, output done, output rdata);
endinterface : cpec_link_if

// ### core/cpec_sum_acc.sv
`timescale 1ns/1ps
// 16-bit checksum accumulator
module cpec_sum_acc (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        clr_i,
   input  wire logic        add_i,
   input  wire logic [15:0] word_i,
   output logic      [15:0] sum_o
);
   logic [15:0] sum_q;

   // carry out of bit 15 simply falls away
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sum_q <= 16'h0000;
      end else if (clr_i) begin
         sum_q <= 16'h0000;
      end else if (add_i) begin
         sum_q <= sum_q + word_i;
      end
   end

   assign sum_o = sum_q;

   a_sum_wrap: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (add_i && !clr_i) |=> sum_o == 16'($past(sum_o) + $past(word_i)))
      else $error("checksum add not modulo 16 bits");
   a_sum_clear: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      clr_i |=> sum_o == 16'h0000)
      else $error("checksum not cleared at start");
endmodule : cpec_sum_acc

// ### core/cpec_link_phy.sv
`timescale 1ns/1ps
// bit engine: divided link clock, command shift out, read frame in
module cpec_link_phy (
   input  wire logic   clk_i,
   input  wire logic   rst_n_i,
   cpec_link_if.phy    link,
   output logic        pclk_o,
   output logic        pdat_o,
   output logic        pdat_oe_n_o,
   input  wire logic   pdat_i
);
   typedef enum logic [1:0] {
      L_IDLE = 2'b00,
      L_CMD  = 2'b01,
      L_DATA = 2'b10,
      L_GAP  = 2'b11
   } cpec_lstate_t;

   cpec_lstate_t st_q;
   logic [4:0]   hcnt_q;
   logic [4:0]   hidx_q;
   logic [4:0]   hnext;
   logic [7:0]   gap_q;
   logic [7:0]   low_cnt_q;
   logic [15:0]  sh_q;
   logic         rd_q;
   logic         done_q;
   logic         clk_q;
   logic         dat_q;
   logic         oe_n_q;
   logic         sync1_q;
   logic         sync2_q;
   logic         half_end;

   assign half_end = (hcnt_q == cpec_pkg::HALF_END);
   assign hnext    = hidx_q + 5'h01;

   // data pin comes from the device, two flops before use
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sync1_q <= 1'b0;
         sync2_q <= 1'b0;
      end else begin
         sync1_q <= pdat_i;
         sync2_q <= sync1_q;
      end
   end

   // frame sequencer; even half periods have the clock high
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_q   <= L_IDLE;
         hcnt_q <= 5'h00;
         hidx_q <= 5'h00;
         gap_q  <= 8'h00;
         sh_q   <= 16'h0000;
         rd_q   <= 1'b0;
         done_q <= 1'b0;
         clk_q  <= 1'b0;
         dat_q  <= 1'b0;
         oe_n_q <= 1'b1;
      end else begin
         done_q <= 1'b0;
         hcnt_q <= half_end ? 5'h00 : hcnt_q + 5'h01;
         unique case (st_q)
            L_IDLE: if (link.req) begin
               st_q   <= L_CMD;
               hcnt_q <= 5'h00;
               hidx_q <= 5'h00;
               clk_q  <= 1'b1;
               dat_q  <= link.cmd[0]; // lsb first
               oe_n_q <= 1'b0;
               rd_q   <= link.rd;
            end
            L_CMD: if (half_end) begin
               if (hidx_q == cpec_pkg::CMD_LAST_HALF) begin
                  st_q   <= L_GAP;
                  gap_q  <= 8'h00;
                  oe_n_q <= 1'b1;
                  dat_q  <= 1'b0;
               end else begin
                  hidx_q <= hnext;
                  clk_q  <= ~clk_q;
                  if (!hnext[0]) begin
                     dat_q <= link.cmd[hnext[3:1]];
                  end
               end
            end
            L_DATA: if (half_end) begin
               if (hidx_q == cpec_pkg::DATA_LAST_HALF) begin
                  st_q  <= L_GAP;
                  gap_q <= 8'h00;
                  rd_q  <= 1'b0;
               end else begin
                  hidx_q <= hnext;
                  clk_q  <= ~clk_q;
                  // sample on the falling edge, after data out valid
                  if (hnext[0]) begin
                     sh_q[hidx_q[4:1]] <= sync2_q;
                  end
               end
            end
            L_GAP: if (gap_q == cpec_pkg::GAP_END) begin
               if (rd_q) begin
                  st_q   <= L_DATA;
                  hcnt_q <= 5'h00;
                  hidx_q <= 5'h00;
                  clk_q  <= 1'b1;
               end else begin
                  st_q   <= L_IDLE;
                  done_q <= 1'b1;
               end
            end else begin
               gap_q <= gap_q + 8'h01;
            end
         endcase
      end
   end

   // start and stop bits dropped, two top bits unused by the 12-bit core
   assign link.rdata  = sh_q[12:1];
   assign link.done   = done_q;
   assign pclk_o      = clk_q;
   assign pdat_o      = dat_q;
   assign pdat_oe_n_o = oe_n_q;

   // cycles the link clock has stayed low, saturating
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         low_cnt_q <= 8'h00;
      end else if (clk_q) begin
         low_cnt_q <= 8'h00;
      end else if (low_cnt_q != 8'hFF) begin
         low_cnt_q <= low_cnt_q + 8'h01;
      end
   end

   a_gap_undriven: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (st_q == L_GAP || st_q == L_DATA) |-> oe_n_q)
      else $error("data pin driven between words");
   a_gap_length: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      ($rose(clk_q) && hidx_q == 5'h00) |-> low_cnt_q >= cpec_pkg::GAP_END)
      else $error("next frame started too soon");
endmodule : cpec_link_phy

// ### core/cpec_prog_ctrl.sv
`timescale 1ns/1ps
module cpec_prog_ctrl #(
   parameter int unsigned ERASE_WAIT_CYC = cpec_pkg::ERASE_CYC,
   parameter int unsigned DISCHARGE_CYC  = cpec_pkg::DIS_CYC
) (
   input  wire logic        core_clk_i,
   input  wire logic        rst_n_i,
   input  wire logic        unprotect_req_i,
   input  wire logic        checksum_req_i,
   output logic             busy_o,
   output logic             done_o,
   output logic             prot_cleared_o,
   output logic             code_protected_o,
   output logic      [15:0] checksum_o,
   output logic             prog_clk_o,
   output logic             prog_data_o,
   output logic             prog_data_oe_n_o,
   input  wire logic        prog_data_i,
   output logic             vpp_en_o
);
   typedef enum logic [2:0] {
      S_IDLE     = 3'b000,
      S_ENTRY    = 3'b001,
      S_ERASE    = 3'b010,
      S_ERA_WAIT = 3'b011,
      S_READ     = 3'b100,
      S_INC      = 3'b101,
      S_EXIT     = 3'b110,
      S_DISCH    = 3'b111
   } cpec_state_t;

   cpec_state_t       st_q;
   cpec_pkg::cpec_tmr_t tmr_q;
   cpec_pkg::cpec_tmr_t since_era_q;
   cpec_pkg::cpec_tmr_t off_cnt_q;
   logic              rst_meta_q;
   logic              rst_sync_q;
   logic              req_q;
   logic              pend_q;
   logic [5:0]        cmd_q;
   logic              rd_q;
   logic [10:0]       addr_q;
   logic [10:0]       addr_nx;
   logic [1:0]        era_cnt_q;
   logic              job_ck_q;
   logic              prot_q;
   logic              cleared_q;
   logic              busy_q;
   logic              done_q;
   logic              vpp_q;
   logic              era_seen_q;
   logic              op_done;
   logic              nx_rd;
   logic [10:0]       last_rd;
   logic [3:0]        id_sh;
   logic [15:0]       rd16;
   logic              sum_add;
   logic              sum_clr;
   logic [15:0]       sum_word;

   cpec_link_if lnk ();

   // reset released through two flops
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_meta_q <= 1'b0;
         rst_sync_q <= 1'b0;
      end else begin
         rst_meta_q <= 1'b1;
         rst_sync_q <= rst_meta_q;
      end
   end

   cpec_link_phy u_phy (
      .clk_i       (core_clk_i),
      .rst_n_i     (rst_sync_q),
      .link        (lnk.phy),
      .pclk_o      (prog_clk_o),
      .pdat_o      (prog_data_o),
      .pdat_oe_n_o (prog_data_oe_n_o),
      .pdat_i      (prog_data_i)
   );

   cpec_sum_acc u_sum (
      .clk_i   (core_clk_i),
      .rst_n_i (rst_sync_q),
      .clr_i   (sum_clr),
      .add_i   (sum_add),
      .word_i  (sum_word),
      .sum_o   (checksum_o)
   );

   assign lnk.req = req_q;
   assign lnk.cmd = cmd_q;
   assign lnk.rd  = rd_q;

   // walk decisions and checksum feed
   assign rd16    = {4'h0, lnk.rdata};
   assign op_done = pend_q && lnk.done;
   assign sum_add = op_done && (st_q == S_READ);
   // unprotect wins if both requests arrive together
   assign sum_clr = (st_q == S_IDLE) && checksum_req_i && !unprotect_req_i;
   assign addr_nx = addr_q + 11'h001;
   assign last_rd = prot_q ? cpec_pkg::ID_LAST : cpec_pkg::PROG_LAST;
   // data block sits between the two windows and is never read
   assign nx_rd   = prot_q ? (addr_nx >= cpec_pkg::ID_FIRST && addr_nx <= cpec_pkg::ID_LAST)
                           : (addr_nx <= cpec_pkg::PROG_LAST);
   assign id_sh   = {~addr_q[1:0], 2'b00};

   // word that this read adds to the checksum
   always_comb begin
      if (addr_q == cpec_pkg::CFG_ADDR) begin
         sum_word = rd16 & cpec_pkg::CFG_MASK;
      end else if (addr_q >= cpec_pkg::ID_FIRST) begin
         sum_word = (rd16 & cpec_pkg::NIB_MASK) << id_sh;
      end else begin
         sum_word = rd16;
      end
   end

   // sequencer: mode entry, erase passes, checksum walk, exit
   always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         st_q      <= S_IDLE;
         tmr_q     <= '0;
         req_q     <= 1'b0;
         pend_q    <= 1'b0;
         cmd_q     <= 6'h00;
         rd_q      <= 1'b0;
         addr_q    <= 11'h000;
         era_cnt_q <= 2'h0;
         job_ck_q  <= 1'b0;
         prot_q    <= 1'b0;
         cleared_q <= 1'b0;
         busy_q    <= 1'b0;
         done_q    <= 1'b0;
         vpp_q     <= 1'b0;
      end else begin
         req_q  <= 1'b0;
         done_q <= 1'b0;
         if (tmr_q != '0) begin
            tmr_q <= tmr_q - 22'h000001;
         end
         unique case (st_q)
            S_IDLE: if (unprotect_req_i || checksum_req_i) begin
               st_q     <= S_ENTRY;
               busy_q   <= 1'b1;
               vpp_q    <= 1'b1;
               job_ck_q <= !unprotect_req_i;
               addr_q   <= cpec_pkg::CFG_ADDR;
               tmr_q    <= cpec_pkg::cpec_tmr_t'(cpec_pkg::HOLD_CYC);
            end
            S_ENTRY: if (tmr_q == '0) begin
               era_cnt_q <= 2'h0;
               // config word comes first so the mode is known
               st_q      <= job_ck_q ? S_READ : S_ERASE;
            end
            S_ERASE: if (!pend_q) begin
               req_q  <= 1'b1;
               pend_q <= 1'b1;
               cmd_q  <= cpec_pkg::CMD_ERASE;
               rd_q   <= 1'b0;
            end else if (lnk.done) begin
               pend_q    <= 1'b0;
               era_cnt_q <= era_cnt_q + 2'h1;
               tmr_q     <= cpec_pkg::cpec_tmr_t'(ERASE_WAIT_CYC);
               st_q      <= S_ERA_WAIT;
            end
            S_ERA_WAIT: if (tmr_q == '0) begin
               if (era_cnt_q == cpec_pkg::ERASE_RUNS) begin
                  cleared_q <= 1'b1;
                  vpp_q     <= 1'b0;
                  tmr_q     <= cpec_pkg::cpec_tmr_t'(cpec_pkg::EXIT_CYC);
                  st_q      <= S_EXIT;
               end else begin
                  st_q <= S_ERASE;
               end
            end
            S_READ: if (!pend_q) begin
               req_q  <= 1'b1;
               pend_q <= 1'b1;
               cmd_q  <= cpec_pkg::CMD_READ;
               rd_q   <= 1'b1;
            end else if (lnk.done) begin
               pend_q <= 1'b0;
               if (addr_q == cpec_pkg::CFG_ADDR) begin
                  prot_q <= (lnk.rdata[cpec_pkg::PROT_MSB:cpec_pkg::PROT_LSB]
                             == cpec_pkg::PROT_ON);
                  st_q   <= S_INC;
               end else if (addr_q == last_rd) begin
                  vpp_q <= 1'b0;
                  tmr_q <= cpec_pkg::cpec_tmr_t'(cpec_pkg::EXIT_CYC);
                  st_q  <= S_EXIT;
               end else begin
                  st_q <= S_INC;
               end
            end
            S_INC: if (!pend_q) begin
               req_q  <= 1'b1;
               pend_q <= 1'b1;
               cmd_q  <= cpec_pkg::CMD_INC;
               rd_q   <= 1'b0;
            end else if (lnk.done) begin
               pend_q <= 1'b0;
               addr_q <= addr_nx;
               // protected parts skip program memory by address steps only
               st_q   <= nx_rd ? S_READ : S_INC;
            end
            S_EXIT: if (tmr_q == '0) begin
               tmr_q <= cpec_pkg::cpec_tmr_t'(DISCHARGE_CYC);
               st_q  <= S_DISCH;
            end
            S_DISCH: if (tmr_q == '0) begin
               busy_q <= 1'b0;
               done_q <= 1'b1;
               st_q   <= S_IDLE;
            end
         endcase
      end
   end

   assign busy_o           = busy_q;
   assign done_o           = done_q;
   assign prot_cleared_o   = cleared_q;
   assign code_protected_o = prot_q;
   assign vpp_en_o         = vpp_q;

   // timing helpers watched only by the checks below
   always_ff @(posedge core_clk_i or negedge rst_sync_q) begin
      if (!rst_sync_q) begin
         since_era_q <= '0;
         off_cnt_q   <= '0;
         era_seen_q  <= 1'b0;
      end else begin
         if (op_done && st_q == S_ERASE) begin
            since_era_q <= '0;
            era_seen_q  <= 1'b1;
         end else if (since_era_q != '1) begin
            since_era_q <= since_era_q + 22'h000001;
         end
         if (st_q == S_IDLE) begin
            era_seen_q <= 1'b0;
         end
         if (vpp_q) begin
            off_cnt_q <= '0;
         end else if (off_cnt_q != '1) begin
            off_cnt_q <= off_cnt_q + 22'h000001;
         end
      end
   end

   sequence s_erase_sent;
      req_q && st_q == S_ERASE;
   endsequence
   sequence s_unprot_exit;
      $fell(vpp_q) && !job_ck_q;
   endsequence

   a_erase_code: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      s_erase_sent |-> cmd_q == cpec_pkg::CMD_ERASE && !rd_q)
      else $error("erase sent with wrong code");
   a_erase_three: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      s_unprot_exit |-> era_cnt_q == cpec_pkg::ERASE_RUNS && cleared_q)
      else $error("unprotect left without three erases");
   a_erase_spacing: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      (req_q && era_seen_q) |-> since_era_q >= ERASE_WAIT_CYC)
      else $error("command sent before erase time elapsed");
   a_exit_quiet: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      !vpp_q |-> !req_q)
      else $error("link used outside program mode");
   a_exit_time: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      done_q |-> off_cnt_q >= cpec_pkg::EXIT_CYC + DISCHARGE_CYC)
      else $error("finished before exit and discharge wait");
   a_cks_clear: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      sum_clr |=> checksum_o == 16'h0000 ##1 (st_q == S_ENTRY))
      else $error("checksum not cleared at start");
   a_cfg_mask: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      (sum_add && addr_q == cpec_pkg::CFG_ADDR) |-> sum_word[15:7] == 9'h000)
      else $error("config word not masked");
   a_data_skip: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      (req_q && rd_q) |-> !(addr_q >= cpec_pkg::DATA_FIRST && addr_q < cpec_pkg::ID_FIRST))
      else $error("data memory read during checksum");
   a_prot_skip: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      (req_q && rd_q && prot_q && addr_q != cpec_pkg::CFG_ADDR) |-> addr_q >= cpec_pkg::ID_FIRST)
      else $error("program memory read while protected");
   a_id_pack: assert property (@(posedge core_clk_i) disable iff (!rst_sync_q)
      (sum_add && addr_q >= cpec_pkg::ID_FIRST && addr_q != cpec_pkg::CFG_ADDR)
      |-> (sum_word >> id_sh) <= cpec_pkg::NIB_MASK)
      else $error("user id nibble misplaced");
endmodule : cpec_prog_ctrl

// ### verif/cpec_dev_model.sv
`timescale 1ns/1ps
// far-side device: takes frame bits on clock falls, drives read data on rises
module cpec_dev_model #(
   parameter real ERASE_NS = 1200.0
) (
   input  wire logic pclk_i,
   input  wire logic pdat_i,
   input  wire logic pdat_oe_n_i,
   input  wire logic vpp_i,
   output logic      pdat_o,
   output int        errs_o,
   output int        erases_o
);
   localparam logic [15:0] IDS = 16'hFFE1;
   logic [11:0] cfg   = 12'h97F;
   logic        wiped = 1'b0;
   logic        rd_ph = 1'b0;
   logic [10:0] pc    = 11'h7FF;
   logic [5:0]  sh    = 6'h00;
   logic [11:0] word  = 12'h000;
   int          nbit  = 0;
   realtime     t_end = -1.0e6;
   realtime     t_gap = 1000.0;

   // memory image; upper id bits set so a missing mask shows
   function automatic logic [11:0] rd_word(input logic [10:0] a);
      if (a == 11'h7FF) return cfg;
      if (a >= 11'h640) return {8'hAB, IDS[4*(3-a[1:0]) +: 4]};
      if (a >= 11'h600) return 12'h555;
      if (wiped) return 12'hFFF;
      return (cfg[10:7] == 4'h2) ? 12'h000 : 12'h723;
   endfunction : rd_word

   initial begin
      pdat_o = 1'b0;
      errs_o = 0;
      erases_o = 0;
   end

   // mode entry puts the address at the config word
   always @(posedge vpp_i) begin
      pc = 11'h7FF;
      nbit = 0;
      rd_ph = 1'b0;
   end

   // gap check at frame start; released line toggles, never holds
   always @(posedge pclk_i) begin
      if (nbit == 0 && $realtime - t_end < t_gap) errs_o++;
      if (rd_ph && nbit >= 1 && nbit <= 14) begin
         if (!pdat_oe_n_i) errs_o++;
         pdat_o <= (nbit <= 12) ? word[nbit-1] : 1'b1;
      end else pdat_o <= ~pdat_o;
   end

   // command decode, lsb first, upper two bits checked only for erase
   always @(negedge pclk_i) begin
      nbit = nbit + 1;
      if (rd_ph && nbit == 16) begin
         rd_ph = 1'b0;
         nbit = 0;
         t_end = $realtime;
      end else if (!rd_ph) begin
         if (pdat_oe_n_i || !vpp_i) errs_o++;
         sh = {pdat_i, sh[5:1]};
      end
      if (!rd_ph && nbit == 6) begin
         nbit = 0;
         t_end = $realtime;
         t_gap = 1000.0;
         if (sh[3:0] == 4'h9) begin
            if (sh !== 6'h09) errs_o++;
            erases_o++;
            t_gap = ERASE_NS;
            if (erases_o == 3) begin
               wiped = 1'b1;
               cfg = 12'hFFF;
            end
         end else if (sh[3:0] == 4'h4) begin
            rd_ph = 1'b1;
            word = rd_word(pc);
         end else if (sh[3:0] == 4'h6) pc = pc + 11'h001;
         else errs_o++;
      end
   end
endmodule : cpec_dev_model

// ### verif/code_protect_erase_and_checksum_tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) check_eq((a) === (b), `__LINE__)
module code_protect_erase_and_checksum_tb_top;
   localparam int unsigned EW = 300;
   localparam int unsigned DW = 50;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic        unp_req = 1'b0;
   logic        sum_req = 1'b0;
   logic        busy, done, cleared, prot, pclk, pdo, pdo_oe_n, vpp, dev_dat;
   logic [15:0] sum;
   wire         pdat_w = pdo_oe_n ? dev_dat : pdo;
   int          fails = 0;
   int          n_compared = 0;
   int          errs, erases;

   always #2 clk = ~clk;

   cpec_prog_ctrl #(.ERASE_WAIT_CYC(EW), .DISCHARGE_CYC(DW)) cpec_prog_ctrl_i (
      .core_clk_i(clk), .rst_n_i(rst_n), .unprotect_req_i(unp_req),
      .checksum_req_i(sum_req), .busy_o(busy), .done_o(done),
      .prot_cleared_o(cleared), .code_protected_o(prot), .checksum_o(sum),
      .prog_clk_o(pclk), .prog_data_o(pdo), .prog_data_oe_n_o(pdo_oe_n),
      .prog_data_i(pdat_w), .vpp_en_o(vpp));

   cpec_dev_model #(.ERASE_NS(EW * 4.0)) cpec_dev_model_i (
      .pclk_i(pclk), .pdat_i(pdo), .pdat_oe_n_i(pdo_oe_n), .vpp_i(vpp),
      .pdat_o(dev_dat), .errs_o(errs), .erases_o(erases));

   task automatic check_eq(input bit ok, input int ln);
      n_compared++;
      if (!ok) begin
         fails++;
         $display("[FAIL] %0t mismatch at bench line %0d", $time, ln);
      end
   endtask : check_eq

   task automatic give_verdict;
      $display("compared %0d, mismatched %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : give_verdict

   // one job; poke raises the checksum request with the unprotect one and
   // again mid-job: unprotect must win, and the busy engine ignores the rest
   task automatic run_job(input bit unp, input bit poke, output int quiet);
      int n;
      n = 0;
      quiet = 0;
      @(posedge clk);
      if (unp) unp_req <= 1'b1;
      sum_req <= !unp || poke;
      @(posedge clk);
      unp_req <= 1'b0;
      sum_req <= 1'b0;
      @(posedge clk);
      #1 `CHK(busy, 1'b1);
      while (done !== 1'b1 && n < 1200000) begin
         @(posedge clk);
         sum_req <= poke && n == 100;
         #1 n++;
         if (unp && vpp === 1'b0 && pclk === 1'b0) quiet++;
      end
      `CHK(done, 1'b1);
      @(posedge clk);
      #1 `CHK(done, 1'b0);
      `CHK(busy, 1'b0);
   endtask : run_job

   // protected part: masked config plus packed ids, carry dropped
   task automatic test_sum_prot;
      int q;
      run_job(1'b0, 1'b0, q);
      `CHK(prot, 1'b1);
      `CHK(sum, 16'(16'h007F + 16'hFFE1));
      $display("test sum_prot finished");
   endtask : test_sum_prot

   // three erases, then quiet link through exit and discharge
   task automatic test_unprotect;
      int q;
      run_job(1'b1, 1'b1, q);
      `CHK(cleared, 1'b1);
      `CHK(erases, 3);
      `CHK(vpp, 1'b0);
      `CHK(q >= cpec_pkg::EXIT_CYC + DW, 1'b1);
      // the joint request ran an unprotect, so the last checksum still stands
      `CHK(sum, 16'(16'h007F + 16'hFFE1));
      repeat (3) @(posedge clk);
      #1 `CHK(busy, 1'b0);
      $display("test unprotect finished");
   endtask : test_unprotect

   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1 `CHK({busy, done, cleared, prot, pclk, pdo_oe_n, vpp}, 7'h02);
      `CHK(sum, 16'h0000);
      test_sum_prot();
      test_unprotect();
      `CHK(errs, 0);
      give_verdict();
   end

   // watchdog well past the long checksum walk
   initial begin
      #6000000;
      fails++;
      give_verdict();
   end
endmodule : code_protect_erase_and_checksum_tb_top
